// file: hw/energy_tariff_selector.v
// Functional notes
// - input bits form binary code, input one lsb
// - encoding one, three inputs: code n is n+1
// - encoding one, two inputs: four tariffs, no idle
// - encoding two, four inputs: 0 none, n tariff n
// - encoding two: codes 1001 up are ignored
// - encoding two, two inputs: 0 none, three tariffs
// - command mode: only bus command sets tariff
// - input mode: inputs alone decide tariff
// - time mode: match day, time, date schedule
// - no weekday from date; feb 29 leap only
// - end minute inclusive through second 59
// - schedule uses utc, offset ignored
// - input one needed; input two beyond two
// - only free or alarm inputs eligible, else error
// - tariff count limited by eligible inputs
// - at most eight tariffs, one accumulates
`include "tariff_consts.vh"
module energy_tariff_selector (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [3:0] tariff_in,
  input wire [3:0] input_busy,
  input wire [10:0] utc_min,
  input wire [2:0] utc_wday,
  input wire [8:0] utc_date,
  input wire leap_year,
  output reg [3:0] active_tariff,
  output reg [7:0] accum_enable,
  output reg assoc_error
);
  // ***************************************************
  // input synchronisers
  // ***************************************************
  // the contacts are asynchronous to pclk, so they pass two flops before
  // any decode; the two cycles of latency are far below any billing step
  reg [3:0] in_meta; // first stage, read only by in_sync
  reg [3:0] in_sync;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
    end else begin
      in_meta <= tariff_in;
      in_sync <= in_meta;
    end
  end
  // ***************************************************
  // software registers
  // ***************************************************
  reg [1:0] mode; // tariff mode select
  reg [3:0] cmd_tariff; // last tariff commanded by the master
  reg cmd_pending; // new command waiting to be applied
  reg encoding; // 0 first encoding, 1 second
  reg [2:0] num_inputs; // inputs used for tariff control
  reg [3:0] num_tariffs; // configured tariff count
  reg [3:0] input_alarm_only; // input shared only with alarms
  reg cfg_reject; // last input config refused
  reg [31:0] local_time_offset_hours; // kept for software only, not applied
  reg [31:0] slot_time [0:7];
  reg [31:0] slot_date [0:7];
  wire setup_phase = psel && !penable;
  // write strobe qualified by pready, so a write lands once per transfer
  wire wr_access = psel && penable && pwrite && pready;
  // the slot window ends right after the eighth slot pair
  wire slot_hit_addr = (paddr >= `OFS_TOD_BASE) && (paddr < `OFS_TOD_END);
  // slot index counts from the window base, so slot 0 sits at the base itself
  wire [11:0] slot_ofs = paddr - `OFS_TOD_BASE;
  wire [2:0] slot_idx = slot_ofs[6:4];
  // an input is eligible when unused or only tied to alarms
  wire [3:0] eligible = ~input_busy | input_alarm_only;
  // requested input config checked before it is taken
  wire [2:0] req_inputs = pwdata[6:4];
  wire [3:0] req_tariffs = pwdata[11:8];
  wire req_enc = pwdata[0];
  reg [3:0] max_tariffs;
  // eligibility must run unbroken from input one; a gap cuts the usable inputs
  reg [2:0] elig_run; // inputs usable from input one upward
  // ***************************************************
  // capacity of the eligible inputs
  // ***************************************************
  always @* begin
    if (!eligible[0]) begin
      elig_run = 3'h0;
    end else if (!eligible[1]) begin
      elig_run = 3'h1;
    end else if (!eligible[2]) begin
      elig_run = 3'h2;
    end else if (!eligible[3]) begin
      elig_run = 3'h3;
    end else begin
      elig_run = 3'h4;
    end
    // encoding one: 2^n tariffs; encoding two: 2^n - 1, capped at eight
    case ({req_enc, (req_inputs > elig_run) ? elig_run : req_inputs})
      4'h1: max_tariffs = 4'h2;
      4'h2: max_tariffs = 4'h4;
      4'h3, 4'h4: max_tariffs = 4'h8;
      4'h9: max_tariffs = 4'h1;
      4'ha: max_tariffs = 4'h3;
      4'hb: max_tariffs = 4'h7;
      4'hc: max_tariffs = 4'h8;
      default: max_tariffs = 4'h0;
    endcase
  end
  // a refused config leaves the old one in force and only raises cfg_reject,
  // so a bad write can never leave the decoder half configured
  // config is legal only with input one free, input two for more than two
  wire cfg_ok = eligible[0] && (req_tariffs != 4'h0) && (req_tariffs <= max_tariffs) &&
    (req_inputs <= elig_run) && ((req_tariffs <= 4'h2) || eligible[1]);
  // ***************************************************
  // apb write path
  // ***************************************************
  integer i;
  // software state changes only in the access cycle, when pready is high;
  // cmd_pending is a one-cycle strobe so a command is applied once, and only in command mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_CMD;
      cmd_tariff <= `TARIFF_NONE;
      cmd_pending <= 1'b0;
      encoding <= 1'b0;
      num_inputs <= 3'h0;
      num_tariffs <= 4'h0;
      input_alarm_only <= 4'h0;
      cfg_reject <= 1'b0;
      local_time_offset_hours <= 32'h0;
      for (i = 0; i < 8; i = i + 1) begin
        slot_time[i] <= 32'h0;
        slot_date[i] <= 32'h0;
      end
    end else begin
      cmd_pending <= 1'b0;
      if (wr_access) begin
        case (paddr)
          `OFS_CTRL: begin
            mode <= pwdata[1:0];
            input_alarm_only <= pwdata[11:8];
            local_time_offset_hours <= {24'h0, pwdata[23:16]};
          end
          `OFS_CMD: begin
            // tariff select command; values above eight are dropped
            if (pwdata[3:0] <= `TARIFF_MAX) begin
              cmd_tariff <= pwdata[3:0];
              cmd_pending <= 1'b1;
            end
          end
          `OFS_INCFG: begin
            if (cfg_ok) begin
              encoding <= req_enc;
              num_inputs <= req_inputs;
              num_tariffs <= req_tariffs;
              cfg_reject <= 1'b0;
            end else begin
              cfg_reject <= 1'b1;
            end
          end
          default: begin
            if (slot_hit_addr && !paddr[3]) begin
              if (paddr[2]) begin
                slot_date[slot_idx] <= pwdata;
              end else begin
                slot_time[slot_idx] <= pwdata;
              end
            end
          end
        endcase
      end
    end
  end
  // ***************************************************
  // apb handshake and read path
  // ***************************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (paddr)
      `OFS_CTRL: rd_mux = {8'h0, local_time_offset_hours[7:0], 4'h0, input_alarm_only, 6'h0, mode};
      `OFS_CMD: rd_mux = {28'h0, cmd_tariff};
      `OFS_INCFG: rd_mux = {20'h0, num_tariffs, 1'b0, num_inputs, 3'h0, encoding};
      `OFS_STATUS: rd_mux = {8'h0, accum_enable, 4'h0, eligible, 2'h0, cfg_reject, assoc_error, active_tariff};
      `OFS_TIME: rd_mux = {8'h0, leap_year, utc_date, utc_wday, utc_min};
      default: begin
        if (slot_hit_addr && !paddr[3]) begin
          rd_mux = paddr[2] ? slot_date[slot_idx] : slot_time[slot_idx];
        end
      end
    endcase
  end
  wire addr_ok = (paddr[1:0] == 2'h0) && ((paddr <= `OFS_TIME) || (slot_hit_addr && !paddr[3]));
  // one wait-free access: pready rises in the access cycle
  // read data is latched in the setup cycle and held until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_ok;
      if (setup_phase && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
  // ***************************************************
  // schedule slots
  // ***************************************************
  // each slot registers its own hit, so the tariff follows the time inputs two
  // edges late; the lowest numbered hitting slot wins should two overlap
  wire [7:0] slot_hit;
  genvar g;
  generate
    for (g = 0; g < `NUM_TARIFF; g = g + 1) begin : slots
      tod_slot u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .cfg_time(slot_time[g]),
        .cfg_date(slot_date[g]),
        .now_min(utc_min), // utc straight, offset never added
        .now_wday(utc_wday),
        .now_date(utc_date),
        .leap_year(leap_year),
        .hit(slot_hit[g])
      );
    end
  endgenerate
  // ***************************************************
  // tariff decode
  // ***************************************************
  // codes beyond the configured tariff count are treated like the invalid
  // codes of encoding two: the previous tariff simply stays active
  reg [3:0] code; // masked binary code of the inputs
  reg [3:0] in_tariff;
  reg in_valid;
  reg [3:0] tod_tariff;
  integer k;
  always @* begin
    // each input is one bit, input one least significant
    case (num_inputs)
      3'h1: code = {3'h0, in_sync[0]};
      3'h2: code = {2'h0, in_sync[1:0]};
      3'h3: code = {1'b0, in_sync[2:0]};
      default: code = in_sync;
    endcase
    in_valid = 1'b1;
    if (!encoding) begin
      // first encoding, no idle code
      in_tariff = code + 4'h1;
      if (code >= num_tariffs) begin
        in_valid = 1'b0;
      end
    end else begin
      // second encoding, zero means no tariff
      in_tariff = code;
      if (code > `ENC2_LIMIT || code > num_tariffs) begin
        in_valid = 1'b0;
      end
    end
    tod_tariff = `TARIFF_NONE;
    for (k = `NUM_TARIFF - 1; k >= 0; k = k - 1) begin
      if (slot_hit[k]) begin
        tod_tariff = k[3:0] + 4'h1;
      end
    end
  end
  // ***************************************************
  // active tariff and accumulation select
  // ***************************************************
  // command mode applies a command once and then holds it; input mode freezes
  // while an association error stands, so a conflicting input cannot steer billing
  reg [3:0] next_tariff;
  always @* begin
    next_tariff = active_tariff;
    case (mode)
      `MODE_CMD: if (cmd_pending) next_tariff = cmd_tariff;
      `MODE_INPUT: if (in_valid && !assoc_error) next_tariff = in_tariff;
      `MODE_TOD: next_tariff = tod_tariff;
      default: next_tariff = active_tariff;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_tariff <= `TARIFF_NONE;
      accum_enable <= 8'h00;
      assoc_error <= 1'b0;
    end else begin
      active_tariff <= next_tariff;
      // one-hot level, held while the tariff stays active: only the active tariff accumulates
      accum_enable <= (next_tariff == `TARIFF_NONE) ? 8'h00 : (8'h01 << (next_tariff - 4'h1));
      // a level, not a sticky flag: it clears once the conflict is removed
      // in input mode, error holds while any used input has a conflicting association
      assoc_error <= (mode == `MODE_INPUT) && (num_inputs != 3'h0) &&
        ((~eligible & ((4'h1 << num_inputs) - 4'h1)) != 4'h0);
    end
  end
endmodule

// file: hw/tariff_consts.vh
`ifndef TARIFF_CONSTS_VH
`define TARIFF_CONSTS_VH
// ***************************************************
// register byte offsets
// ***************************************************
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_INCFG 12'h008
`define OFS_STATUS 12'h00c
`define OFS_TIME 12'h010
`define OFS_TOD_BASE 12'h040
`define OFS_TOD_STEP 12'h010
`define OFS_TOD_END 12'h0c0
// ***************************************************
// field positions and codes
// ***************************************************
`define MODE_CMD 2'h0
`define MODE_INPUT 2'h1
`define MODE_TOD 2'h2
`define DAY_EVERY 3'h0
`define DAY_WEEKDAY 3'h1
`define DAY_WEEKEND 3'h2
`define DAY_SPECIFIC 3'h3
`define TARIFF_NONE 4'h0
`define TARIFF_MAX 4'h8
`define ENC2_LIMIT 4'h8
`define DATE_LEAP_DAY 9'h05d
`define NUM_TARIFF 8
`define NUM_INPUT 4
`endif

// file: hw/tod_slot.v
`include "tariff_consts.vh"
// one schedule slot: matches day type, minute window and date window
module tod_slot (
  input wire pclk,
  input wire presetn,
  input wire [31:0] cfg_time,
  input wire [31:0] cfg_date,
  input wire [10:0] now_min,
  input wire [2:0] now_wday,
  input wire [8:0] now_date,
  input wire leap_year,
  output reg hit
);
  // cfg_time: [10:0] start min, [21:11] end min, [24:22] day type, [27:25] weekday, [31] enable
  // cfg_date: [8:0] start (month*32+day), [17:9] end
  wire [10:0] smin = cfg_time[10:0];
  wire [10:0] emin = cfg_time[21:11];
  wire [2:0] dtype = cfg_time[24:22];
  wire [2:0] wday = cfg_time[27:25];
  wire [8:0] sdate = cfg_date[8:0];
  wire [8:0] edate = cfg_date[17:9];
  reg day_ok;
  reg time_ok;
  reg date_ok;
  // ***************************************************
  // match
  // ***************************************************
  always @* begin
    // weekday comes straight from the clock, never computed from the date
    case (dtype)
      `DAY_EVERY: day_ok = 1'b1;
      `DAY_WEEKDAY: day_ok = (now_wday >= 3'h1) && (now_wday <= 3'h5);
      `DAY_WEEKEND: day_ok = (now_wday == 3'h0) || (now_wday == 3'h6);
      `DAY_SPECIFIC: day_ok = (now_wday == wday);
      default: day_ok = 1'b0;
    endcase
    // whole-minute compare makes the end minute run through second 59
    if (smin <= emin) begin
      time_ok = (now_min >= smin) && (now_min <= emin);
    end else begin
      // wrapping past midnight only for everyday slots
      time_ok = (dtype == `DAY_EVERY) && ((now_min >= smin) || (now_min <= emin));
    end
    // feb 29 (month 2, day 29) counts only in a leap year
    if (!leap_year && (now_date == `DATE_LEAP_DAY)) begin
      date_ok = 1'b0;
    end else if (sdate <= edate) begin
      date_ok = (now_date >= sdate) && (now_date <= edate);
    end else begin
      date_ok = (now_date >= sdate) || (now_date <= edate);
    end
  end
  // registered hit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit <= 1'b0;
    end else begin
      hit <= cfg_time[31] && day_ok && time_ok && date_ok;
    end
  end
endmodule

// file: tb/contact_bank.sv
// ***************************************************
// external contacts: levels change only on a clock edge
// ***************************************************
module contact_bank (
  input wire pclk,
  input wire [3:0] code,
  input wire [3:0] busy,
  output logic [3:0] tariff_in,
  output logic [3:0] input_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts and their other associations, no bounce modelled
  always @(posedge pclk) begin
    tariff_in <= code;
    input_busy <= busy;
  end
endmodule

// file: tb/tariff_chk.sv
`include "tariff_consts.vh"
// ***************************************************
// bus handshake and tariff output checks
// ***************************************************
module tariff_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [3:0] active_tariff,
  input wire [7:0] accum_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [1:0] mode; // mode as last written by software
  wire wacc; // completed write access
  wire cmd_ok; // legal tariff command in command mode
  assign wacc = psel && penable && pwrite && pready;
  assign cmd_ok = wacc && paddr == `OFS_CMD && mode == `MODE_CMD && pwdata[3:0] <= `TARIFF_MAX;
  // shadow of the mode field, so commands are only judged in command mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_CMD;
    end else if (wacc && paddr == `OFS_CTRL) begin
      mode <= pwdata[1:0];
    end
  end
  setup_gets_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  bad_addr_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("unaligned access not refused");
  good_addr_ok_a: assert property (psel && !penable && paddr == `OFS_STATUS |=> pready && !pslverr)
    else $error("mapped access refused");
  one_sink_a: assert property ($onehot0(accum_enable)) else $error("several tariffs accumulate");
  tariff_range_a: assert property (active_tariff <= `TARIFF_MAX) else $error("tariff out of range");
  cmd_apply_a: assert property (cmd_ok |-> ##2 active_tariff == $past(pwdata[3:0], 2))
    else $error("command tariff not applied");
  cover property (cmd_ok);
  cover property (pready && pslverr);
  cover property (active_tariff != $past(active_tariff));
endmodule
bind energy_tariff_selector tariff_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .active_tariff(active_tariff),
  .accum_enable(accum_enable)
);

// file: tb/test_energy_tariff_selector.sv
`include "tariff_consts.vh"
module test_energy_tariff_selector;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic [3:0] code = 4'h0, busy = 4'h0, tin, tbusy;
  logic [10:0] utc_min = 11'h000;
  logic [2:0] utc_wday = 3'h0;
  logic [8:0] utc_date = 9'h0a5; // may 5, inside the dates of the five programmed slots 0 to 4
  logic leap_year = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, assoc_error;
  wire [3:0] active_tariff;
  wire [7:0] accum_enable;
  int n_errors = 0, tests_run = 0, cyc = 0;
  // schedule probes: minute, weekday and expected tariff per step
  int mins[9] = '{75, 76, 121, 250, 250, 450, 450, 650, 650};
  int days[9] = '{3, 3, 3, 0, 1, 6, 2, 3, 4};
  int exps[9] = '{1, 2, 0, 0, 3, 4, 0, 5, 0};
  always #2 pclk = ~pclk;
  contact_bank bank_u (.pclk(pclk), .code(code), .busy(busy), .tariff_in(tin), .input_busy(tbusy));
  energy_tariff_selector dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tariff_in(tin), .input_busy(tbusy), .utc_min(utc_min), .utc_wday(utc_wday), .utc_date(utc_date),
    .leap_year(leap_year), .active_tariff(active_tariff), .accum_enable(accum_enable),
    .assoc_error(assoc_error));
  // ***************************************************
  // bus master and compare tasks
  // ***************************************************
  // one transfer; an idle edge follows so psel is never driven twice at once
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // lets the input sync and decode path settle, then checks both outputs
  task chk_tar(input logic [3:0] x);
    repeat (6) @(posedge pclk);
    chk("active_tariff", {28'h0, x}, {28'h0, active_tariff});
    chk("accum_enable", (x == 4'h0) ? 32'h0 : 32'h1 << (x - 4'h1), {24'h0, accum_enable});
  endtask
  // walks every contact code under one input configuration
  task run_in(input logic [31:0] cfg);
    logic [3:0] m, c, e;
    m = (4'h1 << cfg[6:4]) - 4'h1;
    e = 4'h0;
    apb(1'b1, `OFS_INCFG, cfg);
    for (int i = 0; i < 16; i++) begin
      c = i[3:0] & m;
      if (cfg[0] && c <= cfg[11:8]) e = c;
      else if (!cfg[0] && c < cfg[11:8]) e = c + 4'h1;
      code <= i[3:0];
      chk_tar(e);
    end
    apb(1'b1, `OFS_CMD, 32'h2);
    chk_tar(e);
    $display("test input cfg %h done", cfg);
  endtask
  function automatic logic [31:0] tw(input int s, input int t, input logic [2:0] d, input logic [2:0] w);
    tw = {1'b1, 3'h0, w, d, t[10:0], s[10:0]};
  endfunction
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well above the roughly seven hundred cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      print_verdict;
    end
  end
  // ***************************************************
  // test sequence
  // ***************************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_tar(4'h0);
    for (int i = 0; i <= 9; i++) begin
      apb(1'b1, `OFS_CMD, i);
      chk_tar((i == 9) ? 4'h8 : i[3:0]);
    end
    apb(1'b1, 12'h006, 32'h1);
    chk("unaligned_err", 32'h1, {31'h0, serr});
    chk_tar(4'h8);
    $display("test command mode done");
    busy <= 4'h2;
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_INCFG, 32'h420);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("reject_eligible", 32'h0d20, q & 32'h0f20);
    busy <= 4'h1;
    apb(1'b1, `OFS_CTRL, 32'h101);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("alarm_eligible", 32'h0f00, q & 32'h0f00);
    busy <= 4'h0;
    $display("test eligibility done");
    run_in(32'h830);
    run_in(32'h420);
    run_in(32'h841);
    run_in(32'h321);
    busy <= 4'h2;
    code <= 4'h1;
    chk_tar(4'h3);
    chk("assoc_error", 32'h1, {31'h0, assoc_error});
    busy <= 4'h0;
    chk_tar(4'h1);
    chk("assoc_error", 32'h0, {31'h0, assoc_error});
    $display("test association error done");
    apb(1'b1, `OFS_TOD_BASE, tw(60, 75, `DAY_EVERY, 3'h0));
    apb(1'b1, `OFS_TOD_BASE + 12'h010, tw(76, 120, `DAY_EVERY, 3'h0));
    apb(1'b1, `OFS_TOD_BASE + 12'h020, tw(200, 300, `DAY_WEEKDAY, 3'h0));
    apb(1'b1, `OFS_TOD_BASE + 12'h030, tw(400, 500, `DAY_WEEKEND, 3'h0));
    apb(1'b1, `OFS_TOD_BASE + 12'h040, tw(600, 700, `DAY_SPECIFIC, 3'h3));
    for (int k = 0; k < 5; k++) apb(1'b1, `OFS_TOD_BASE + 12'h004 + 12'h010 * k, {14'h0, 9'd415, 9'd33});
    apb(1'b1, `OFS_CTRL, 32'h00050002);
    for (int i = 0; i < 9; i++) begin
      utc_min <= mins[i][10:0];
      utc_wday <= days[i][2:0];
      chk_tar(exps[i][3:0]);
    end
    utc_min <= 11'd250;
    utc_wday <= 3'h1;
    utc_date <= `DATE_LEAP_DAY;
    chk_tar(4'h0);
    leap_year <= 1'b1;
    chk_tar(4'h3);
    apb(1'b1, `OFS_CMD, 32'h5);
    chk_tar(4'h3);
    $display("test time of day done");
    print_verdict;
  end
endmodule
